// File: lwc_pkg.sv
// Shared types and constants for the long table write controller.
`default_nettype none
package lwc_pkg;

   // Number of core interrupt sources whose flags this block may clear.
   localparam int unsigned NUM_CORE = 3;
   // Core source positions; a lower index is a higher priority.
   localparam int unsigned SRC_EXT_PIN = 0;
   localparam int unsigned SRC_TIMER0 = 1;
   localparam int unsigned SRC_T0_CLK_PIN = 2;
   // Width of the long write length counter.
   localparam int unsigned LEN_WIDTH = 16;
   // Reset value of the length counter.
   localparam logic [LEN_WIDTH-1:0] LEN_RESET = 16'h0000;
   // Reset value of the core flag clear strobes.
   localparam logic [NUM_CORE-1:0] CLR_NONE = 3'h0;

   // Controller states.
   typedef enum logic [1:0] {
      LWC_IDLE = 2'b00,
      LWC_LONG_WRITE = 2'b01,
      LWC_FINISH = 2'b10
   } lwc_state_t;

   // Interrupt enables and flags as seen by the controller.
   typedef struct packed {
      logic global_interrupt_disable;
      logic [NUM_CORE-1:0] core_en;
      logic [NUM_CORE-1:0] core_flag;
      logic periph_en;
      logic periph_flag;
   } lwc_irq_t;

   // Table write request from the instruction sequencer.
   typedef struct packed {
      logic valid;
      logic internal;
   } lwc_tw_req_t;

   // Sequencer controls returned to the core.
   typedef struct packed {
      logic exec_hold;
      logic prog_active;
      logic nop_exec;
      logic vector_req;
      logic resume_next;
      logic tw_done;
   } lwc_seq_t;

   localparam lwc_seq_t SEQ_RESET = '{default: 1'b0};

endpackage : lwc_pkg
`default_nettype wire

// File: lwc_prio.sv
// Priority pick among enabled and pending core interrupt sources.
`timescale 1ns/1ps
`default_nettype none
module lwc_prio #(
   parameter int unsigned N = 3
) (
   // Source state.
   input wire logic [N-1:0] en,
   input wire logic [N-1:0] flag,
   // Result.
   output logic [N-1:0] sel,
   output logic any
);

   // Lowest index that is both enabled and flagged wins.
   always_comb begin
      sel = '0;
      any = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (en[i] && flag[i]) begin
            sel = '0;
            sel[i] = 1'b1;
            any = 1'b1;
         end
      end
   end

endmodule : lwc_prio
`default_nettype wire

// File: lwc_len.sv
// Saturating counter of the cycles spent in a long write.
`timescale 1ns/1ps
`default_nettype none
module lwc_len #(
   parameter int unsigned W = lwc_pkg::LEN_WIDTH
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Control.
   input wire logic start,
   input wire logic run,
   // Count.
   output logic [W-1:0] count
);

   logic [W-1:0] next_count;

   // Restart on a new write, count while it runs, hold at the top.
   always_comb begin
      next_count = count;
      if (start) begin
         next_count = {{(W-1){1'b0}}, 1'b1};
      end else if (run && (count != {W{1'b1}})) begin
         next_count = count + {{(W-1){1'b0}}, 1'b1};
      end
   end

   // Register the count.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

endmodule : lwc_len
`default_nettype wire

// File: lwc_ctrl.sv
// Long table write controller: holds the core while program memory is written.
`timescale 1ns/1ps
`default_nettype none
module lwc_ctrl #(
   parameter int unsigned LEN_W = lwc_pkg::LEN_WIDTH
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Instruction sequencer request.
   input wire lwc_pkg::lwc_tw_req_t tw_req,
   // Interrupt logic state.
   input wire lwc_pkg::lwc_irq_t irq,
   // Sequencer controls.
   output lwc_pkg::lwc_seq_t seq,
   // Core flag clear strobes, one per core source.
   output logic [lwc_pkg::NUM_CORE-1:0] core_flag_clr,
   // Length of the current or last long write in cycles.
   output logic [LEN_W-1:0] write_cycles
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations.

   lwc_pkg::lwc_state_t state;
   lwc_pkg::lwc_state_t next_state;
   lwc_pkg::lwc_seq_t next_seq;
   logic [lwc_pkg::NUM_CORE-1:0] next_core_flag_clr;
   logic gid_at_start;
   logic next_gid_at_start;
   logic [lwc_pkg::NUM_CORE-1:0] core_sel;
   logic core_any;
   logic periph_any;
   logic term;
   logic len_start;

   ////////////////////////////////////////////////////////////////////////
   // Source qualification.

   // A source counts only with both its enable and its flag set.
   lwc_prio #(
      .N(lwc_pkg::NUM_CORE)
   ) u_prio (
      .en(irq.core_en),
      .flag(irq.core_flag),
      .sel(core_sel),
      .any(core_any)
   );

   // A source is live only with both its enable and its flag set.
   function automatic logic src_live(input logic en, input logic flag);
      return en & flag;
   endfunction : src_live

   // Peripheral source, qualified the same way; the global disable is
   // deliberately left out so it cannot block termination.
   assign periph_any = src_live(irq.periph_en, irq.periph_flag);
   assign term = core_any | periph_any;

   ////////////////////////////////////////////////////////////////////////
   // Write length counter.

   assign len_start = (state == lwc_pkg::LWC_IDLE) && tw_req.valid &&
      tw_req.internal && !term;

   lwc_len #(
      .W(LEN_W)
   ) u_len (
      .core_clk(core_clk),
      .rstn(rstn),
      .start(len_start),
      .run(state == lwc_pkg::LWC_LONG_WRITE),
      .count(write_cycles)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer.

   // Next state and output strobes.
   always_comb begin
      next_state = state;
      next_seq = seq;
      next_seq.nop_exec = 1'b0;
      next_seq.vector_req = 1'b0;
      next_seq.resume_next = 1'b0;
      next_seq.tw_done = 1'b0;
      next_core_flag_clr = lwc_pkg::CLR_NONE;
      next_gid_at_start = gid_at_start;
      case (state)
         lwc_pkg::LWC_IDLE: begin
            if (tw_req.valid) begin
               if (term) begin
                  // Already pending: drop the write, run a no-operation.
                  next_seq.nop_exec = 1'b1;
                  next_seq.tw_done = 1'b1;
                  next_core_flag_clr = core_sel;
               end else if (tw_req.internal) begin
                  // Long write starts; remember the global disable now.
                  next_state = lwc_pkg::LWC_LONG_WRITE;
                  next_seq.exec_hold = 1'b1;
                  next_seq.prog_active = 1'b1;
                  next_gid_at_start = irq.global_interrupt_disable;
               end else begin
                  // External memory write needs no long cycle.
                  next_seq.tw_done = 1'b1;
               end
            end
         end
         lwc_pkg::LWC_LONG_WRITE: begin
            if (term) begin
               next_state = lwc_pkg::LWC_FINISH;
               next_seq.prog_active = 1'b0;
               // Core source flag is cleared by the branch or directly;
               // a peripheral flag is left alone.
               next_core_flag_clr = core_sel;
            end
         end
         lwc_pkg::LWC_FINISH: begin
            next_state = lwc_pkg::LWC_IDLE;
            next_seq.exec_hold = 1'b0;
            next_seq.tw_done = 1'b1;
            if (!gid_at_start) begin
               next_seq.vector_req = 1'b1;
            end else begin
               next_seq.resume_next = 1'b1;
            end
         end
         default: begin
            next_state = lwc_pkg::LWC_IDLE;
            next_seq = lwc_pkg::SEQ_RESET;
         end
      endcase
   end

   // Register state; a reset ends any long write at once.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state <= lwc_pkg::LWC_IDLE;
         seq <= lwc_pkg::SEQ_RESET;
         core_flag_clr <= lwc_pkg::CLR_NONE;
         gid_at_start <= 1'b0;
      end else begin
         state <= next_state;
         seq <= next_seq;
         core_flag_clr <= next_core_flag_clr;
         gid_at_start <= next_gid_at_start;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   // An internal write with nothing pending halts execution next cycle.
   AST_START_HOLD: assert property (
      (state == lwc_pkg::LWC_IDLE && tw_req.valid && tw_req.internal && !term)
      |=> (seq.exec_hold && seq.prog_active))
      else $error("Long write did not halt execution.");

   // Without a qualified source the long write continues.
   AST_NO_EARLY_END: assert property (
      (state == lwc_pkg::LWC_LONG_WRITE && !term)
      |=> (state == lwc_pkg::LWC_LONG_WRITE && seq.exec_hold))
      else $error("Long write ended without an enabled interrupt.");

   // A qualified source ends programming the next cycle.
   AST_TERM_ENDS: assert property (
      (state == lwc_pkg::LWC_LONG_WRITE && term)
      |=> (!seq.prog_active ##1 !seq.exec_hold))
      else $error("Qualified interrupt did not end the long write.");

   // The global disable does not keep the write running.
   AST_GID_NO_GATE: assert property (
      (state == lwc_pkg::LWC_LONG_WRITE && term &&
       irq.global_interrupt_disable) |=> (state == lwc_pkg::LWC_FINISH))
      else $error("Global disable gated termination.");

   // Clear disable at the start gives a vector two cycles after the end.
   AST_VECTOR: assert property (
      (state == lwc_pkg::LWC_LONG_WRITE && term && !gid_at_start)
      |=> ##1 (seq.vector_req && !seq.resume_next))
      else $error("No vector after termination with disable clear.");

   // Set disable at the start gives a resume and no vector.
   AST_NO_VECTOR: assert property (
      (state == lwc_pkg::LWC_LONG_WRITE && term && gid_at_start)
      |=> ##1 (!seq.vector_req && seq.resume_next))
      else $error("Vector taken with disable set.");

   // The winning core flag is cleared as the write ends.
   AST_CORE_CLEAR: assert property (
      (state == lwc_pkg::LWC_LONG_WRITE && core_any)
      |=> (core_flag_clr == $past(core_sel) && $onehot(core_flag_clr)))
      else $error("Core flag not cleared on termination.");

   // Core source with disable clear: terminate, clear, then vector.
   AST_CORE_VECTOR: assert property (
      (state == lwc_pkg::LWC_LONG_WRITE && core_any && !gid_at_start)
      |=> (core_flag_clr != lwc_pkg::CLR_NONE) ##1 seq.vector_req)
      else $error("Core termination sequence wrong.");

   // A peripheral-only termination never clears a core flag.
   AST_PERIPH_KEEP: assert property (
      (state == lwc_pkg::LWC_LONG_WRITE && periph_any && !core_any)
      |=> (core_flag_clr == lwc_pkg::CLR_NONE))
      else $error("Peripheral termination cleared a flag.");

   // A pending source at issue aborts with a no-operation.
   AST_ABORT: assert property (
      (state == lwc_pkg::LWC_IDLE && tw_req.valid && term)
      |=> (seq.nop_exec && !seq.exec_hold && core_flag_clr == $past(core_sel)))
      else $error("Pending interrupt did not abort the write.");

   // Resume and vector never come together.
   AST_EXCLUSIVE: assert property (
      !(seq.vector_req && seq.resume_next))
      else $error("Vector and resume both asserted.");

   // Programming runs only inside a long write, with execution held.
   AST_PROG_IN_WRITE: assert property (
      seq.prog_active |-> (state == lwc_pkg::LWC_LONG_WRITE && seq.exec_hold))
      else $error("Programming active outside a long write.");

   // The length counter steps once for every cycle of a long write until it reaches its top value.
   AST_LEN_STEP: assert property (
      (state == lwc_pkg::LWC_LONG_WRITE && write_cycles != {LEN_W{1'b1}})
      |=> ($past(write_cycles) == write_cycles - {{(LEN_W-1){1'b0}}, 1'b1}))
      else $error("Write length counter did not step.");

   // A table write that arrives during a long write is ignored.
   AST_BUSY_REFUSE: assert property (
      (state == lwc_pkg::LWC_LONG_WRITE && tw_req.valid)
      |=> (!seq.tw_done && !seq.nop_exec))
      else $error("Table write taken during a long write.");

   // At most one core flag is cleared in any cycle.
   AST_CLR_ONEHOT: assert property (
      $onehot0(core_flag_clr))
      else $error("More than one core flag cleared.");

   // A flag clear always follows a qualified core source.
   AST_CLR_CAUSE: assert property (
      (core_flag_clr != lwc_pkg::CLR_NONE) |-> $past(core_any))
      else $error("Core flag cleared without a qualified source.");

   // Every finished table write leaves execution running.
   AST_DONE_FREE: assert property (
      seq.tw_done |-> !seq.exec_hold)
      else $error("Table write finished with execution still held.");

   // A vector or a resume only comes as the instruction finishes.
   AST_END_WITH_DONE: assert property (
      (seq.vector_req || seq.resume_next) |-> seq.tw_done)
      else $error("Vector or resume without a finished write.");

   // A peripheral termination with the disable clear still vectors.
   AST_PERIPH_VECTOR: assert property (
      (state == lwc_pkg::LWC_LONG_WRITE && !core_any && !gid_at_start &&
       src_live(irq.periph_en, irq.periph_flag))
      |=> ##1 seq.vector_req)
      else $error("Peripheral termination did not vector.");

   // The global disable is captured when the long write is taken.
   AST_GID_LATCH: assert property (
      len_start
      |=> (gid_at_start == $past(irq.global_interrupt_disable)))
      else $error("Global disable not captured at the write start.");

   // The finish cycle keeps execution held with programming stopped.
   AST_FINISH_HOLD: assert property (
      (state == lwc_pkg::LWC_FINISH) |-> (seq.exec_hold && !seq.prog_active))
      else $error("Finish cycle outputs wrong.");

   // An aborted write never enters the long write.
   AST_ABORT_IDLE: assert property (
      (state == lwc_pkg::LWC_IDLE && tw_req.valid && term)
      |=> (state == lwc_pkg::LWC_IDLE && !seq.prog_active))
      else $error("Aborted write started programming.");

   // Main scenarios.
   COV_VECTOR: cover property (
      (state == lwc_pkg::LWC_LONG_WRITE) ##1 seq.vector_req);
   COV_RESUME: cover property (
      (state == lwc_pkg::LWC_LONG_WRITE) ##1 seq.resume_next);
   COV_ABORT: cover property (seq.nop_exec);
   COV_PERIPH: cover property (
      state == lwc_pkg::LWC_LONG_WRITE && periph_any && !core_any);
   COV_EXTERNAL: cover property (
      seq.tw_done && !seq.nop_exec && !seq.vector_req && !seq.resume_next);

endmodule : lwc_ctrl
`default_nettype wire

// File: lwc_core_model.sv
// Model of the core interrupt logic that faces the write controller.
`timescale 1ns/1ps
`default_nettype none
module lwc_core_model (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Software view of enables and global disable.
   input wire logic gid,
   input wire logic [2:0] en,
   input wire logic pen,
   // Source events that raise flags.
   input wire logic [2:0] set_core,
   input wire logic set_periph,
   // Clear strobes from the controller.
   input wire logic [2:0] core_flag_clr,
   // Interrupt state seen by the controller.
   output lwc_pkg::lwc_irq_t irq
);
   logic [2:0] flag;
   logic pflag;
   logic [2:0] next_flag;
   logic next_pflag;
   // Flags stay set until a clear strobe; peripheral flags are never cleared.
   // A new event in the cycle of a clear wins, so no interrupt is lost.
   always_comb begin
      next_flag = (flag & ~core_flag_clr) | set_core;
      next_pflag = pflag | set_periph;
   end
   // Register the flags.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         flag <= 3'h0;
         pflag <= 1'b0;
      end else begin
         flag <= next_flag;
         pflag <= next_pflag;
      end
   end
   // Present the state, with only the chosen sources enabled.
   assign irq = {gid, en, flag, pen, pflag};
endmodule : lwc_core_model
`default_nettype wire

// File: testbench.sv
// Self-checking testbench for the long table write controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic gid = 1'b0;
   logic [2:0] en = 3'h0;
   logic pen = 1'b0;
   logic [2:0] set_core = 3'h0;
   logic set_periph = 1'b0;
   lwc_pkg::lwc_tw_req_t tw_req = '0;
   lwc_pkg::lwc_irq_t irq;
   lwc_pkg::lwc_seq_t seq;
   logic [2:0] clr;
   logic [7:0] cyc;
   int n_fail = 0;
   int n_compared = 0;
   //////////////////////////////////////////////////////////////
   // Clock at 10 MHz.
   always #50 core_clk = ~core_clk;
   lwc_ctrl #(.LEN_W(8)) DUT (.core_clk(core_clk), .rstn(rstn),
      .tw_req(tw_req), .irq(irq), .seq(seq), .core_flag_clr(clr),
      .write_cycles(cyc));
   lwc_core_model core (.core_clk(core_clk), .rstn(rstn), .gid(gid),
      .en(en), .pen(pen), .set_core(set_core), .set_periph(set_periph),
      .core_flag_clr(clr), .irq(irq));
   //////////////////////////////////////////////////////////////
   // Report and end the run.
   task automatic stop_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   // Compare a bit vector result.
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // Reset for five cycles and clear all stimulus.
   task automatic rst;
      @(negedge core_clk);
      {rstn, gid, en, pen, set_core, set_periph, tw_req} = '0;
      repeat (5) @(negedge core_clk);
      rstn = 1'b1;
      @(negedge core_clk);
   endtask : rst
   // Raise source events for one cycle.
   task automatic fire(input logic [2:0] c, input logic p);
      set_core = c;
      set_periph = p;
      @(negedge core_clk);
      {set_core, set_periph} = '0;
   endtask : fire
   // Issue a table write; returns in the cycle after it is taken.
   task automatic issue(input logic internal);
      tw_req = '{valid: 1'b1, internal: internal};
      @(negedge core_clk);
      tw_req = '0;
   endtask : issue
   //////////////////////////////////////////////////////////////
   // Long write ended by the given source, checking the outcome.
   task automatic long_write(input logic g, input logic [2:0] e,
      input logic pe, input logic [2:0] fc, input logic fp,
      input logic [2:0] exp_clr, input logic vec);
      logic [2:0] seen;
      logic [2:0] exp_flag;
      logic exp_pflag;
      int i;
      seen = 3'h0;
      // Only the terminating source loses its flag; the rest stay.
      exp_flag = (~e | fc) & ~exp_clr;
      exp_pflag = fp | ~pe;
      rst();
      {gid, en, pen} = {g, e, pe};
      issue(1'b1);
      cmp(seq, 16'h0030);
      cmp(cyc, 16'h0001);
      fire(~e, ~pe);
      repeat (3) @(negedge core_clk);
      cmp(seq.exec_hold, 16'h0001);
      gid = ~g;
      fire(fc, fp);
      for (i = 0; i < 10 && seq.tw_done !== 1'b1; i++) begin
         seen = seen | clr;
         @(negedge core_clk);
      end
      cmp(seq, {13'h0000, vec, ~vec, 1'b1});
      cmp(seen, exp_clr);
      cmp(irq.core_flag & exp_clr, 16'h0000);
      cmp(irq.core_flag, exp_flag);
      cmp(irq.periph_flag, exp_pflag);
   endtask : long_write
   // Pending enabled sources abort the write with a no-operation.
   task automatic abort_write;
      rst();
      en = 3'h7;
      fire(3'h6, 1'b0);
      issue(1'b1);
      cmp(seq, 16'h0009);
      cmp(clr, 16'h0002);
      @(negedge core_clk);
      cmp(seq, 16'h0000);
      cmp(irq.core_flag, 16'h0004);
   endtask : abort_write
   // A write to external memory finishes at once.
   task automatic external_write;
      rst();
      issue(1'b0);
      cmp(seq, 16'h0001);
      cmp(cyc, 16'h0000);
   endtask : external_write
   // Reset ends a long write.
   task automatic reset_write;
      rst();
      issue(1'b1);
      @(negedge core_clk);
      // A second request during the long write must be ignored.
      issue(1'b0);
      cmp(seq, 16'h0030);
      cmp(cyc, 16'h0003);
      rstn = 1'b0;
      @(negedge core_clk);
      cmp(seq, 16'h0000);
      cmp(cyc, 16'h0000);
      rstn = 1'b1;
   endtask : reset_write
   //////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      long_write(1'b0, 3'h1, 1'b0, 3'h1, 1'b0, 3'h1, 1'b1);
      long_write(1'b1, 3'h2, 1'b0, 3'h2, 1'b0, 3'h2, 1'b0);
      long_write(1'b1, 3'h4, 1'b0, 3'h4, 1'b0, 3'h4, 1'b0);
      long_write(1'b1, 3'h3, 1'b0, 3'h3, 1'b0, 3'h1, 1'b0);
      long_write(1'b0, 3'h0, 1'b1, 3'h0, 1'b1, 3'h0, 1'b1);
      long_write(1'b1, 3'h0, 1'b1, 3'h0, 1'b1, 3'h0, 1'b0);
      abort_write();
      external_write();
      reset_write();
      stop_test();
   end
   // Watchdog against a hung run.
   initial begin
      #400000;
      n_fail++;
      stop_test();
   end
endmodule : testbench
`default_nettype wire
